// *** mdr_div.sv ***
// module: restoring 32/16 unsigned divider, one bit per cycle
`timescale 1ns/1ps
module mdr_div
  import mdr_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic           core_clk,
  input  wire logic           reset,
  input  wire logic           start,
  input  wire logic [2*W-1:0] dividend,
  input  wire logic [W-1:0]   divisor,
  output logic                busy,
  output logic                done,
  output logic [W-1:0]        quotient,
  output logic [W-1:0]        remainder
);
  logic [2*W-1:0] num_reg;
  logic [W:0]     rem_reg;
  logic [W-1:0]   dvs_reg;
  logic [5:0]     cnt_reg;
  logic [W:0]     trial;

  always_comb begin
    trial = {rem_reg[W-1:0], num_reg[2*W-1]} - {1'b0, dvs_reg};
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      num_reg <= '0;
      rem_reg <= '0;
      dvs_reg <= '0;
      cnt_reg <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        num_reg <= dividend;
        rem_reg <= '0;
        dvs_reg <= divisor;
        cnt_reg <= 6'(2*W);
        busy    <= 1'b1;
      end else if (busy) begin
        num_reg <= {num_reg[2*W-2:0], ~trial[W]};
        rem_reg <= trial[W] ? {rem_reg[W-1:0], num_reg[2*W-1]} : trial;
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign quotient  = num_reg[W-1:0];
  assign remainder = rem_reg[W-1:0];
endmodule // mdr_div

// *** mdr_mult.sv ***
// module: 16x16 unsigned multiplier, one cycle registered
`timescale 1ns/1ps
module mdr_mult
  import mdr_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic           core_clk,
  input  wire logic           reset,
  input  wire logic           start,
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  output logic                done,
  output logic [2*W-1:0]      product
);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done    <= 1'b0;
      product <= '0;
    end else begin
      done <= start;
      if (start) begin
        product <= a * b;
      end
    end
  end
endmodule // mdr_mult

// *** mdr_pkg.sv ***
// package: constants for the multiply/divide result register block
package mdr_pkg;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned ADDR_W      = 4;
  localparam logic [3:0]  ADDR_HIGH   = 4'h0;
  localparam logic [3:0]  ADDR_LOW    = 4'h1;
  localparam logic [3:0]  ADDR_CTRL   = 4'h2;
  localparam int unsigned IN_USE_BIT  = 4;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_MASK   = 16'h00ff;
  localparam int unsigned DIV_STEPS   = 16;

  typedef enum logic [1:0] {
    MDR_OP_MUL  = 2'h0,
    MDR_OP_DIVU = 2'h1,
    MDR_OP_DIVL = 2'h2,
    MDR_OP_DIVS = 2'h3
  } mdr_op_t;

  typedef enum logic [2:0] {
    MDR_ST_IDLE = 3'b001,
    MDR_ST_BUSY = 3'b010,
    MDR_ST_DONE = 3'b100
  } mdr_state_t;
endpackage

// *** mdr_seq_model.sv ***
// sequencer model: issues single-cycle operation starts and waits for completion
`timescale 1ns/1ps
module mdr_seq_model
  import mdr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        op_done,
  output logic             op_start,
  output mdr_pkg::mdr_op_t op_kind,
  output logic [15:0]      op_divisor
);
  initial begin
    op_start   = 1'b0;
    op_kind    = MDR_OP_MUL;
    op_divisor = 16'h0000;
  end

  // one-cycle start with kind and divisor beside it
  task automatic start(input mdr_op_t k, input logic [15:0] dv);
    @(posedge core_clk);
    op_start   <= 1'b1;
    op_kind    <= k;
    op_divisor <= dv;
    @(posedge core_clk);
    op_start   <= 1'b0;
    op_divisor <= ~dv;
  endtask

  // bounded wait for the completion pulse
  task automatic wait_done(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge core_clk);
      #1 ok = op_done;
    end
  endtask
endmodule // mdr_seq_model

// *** mdr_top.sv ***
// module: multiply/divide operand and result registers with control flag
//
// Functional notes
// RL1: after a multiply completes the high word holds product bits 31..16.
// RL2: after a multiply completes the low word holds product bits 15..0.
// RL3: software loads the dividend high half into high word and low half into low word before a divide.
// RL4: after a divide completes the high word holds the remainder.
// RL5: after a divide completes the low word holds the quotient.
// RL6: a software write to the high or low word sets the in-use flag.
// RL7: a software read of the low word clears the in-use flag, a high read does not.
// RL8: reset loads zero into both high and low word.
// RL9: an interrupting handler saves high, low and control before starting its own operation.
// RL10: high and low words are accessed only as whole 16-bit words.
// RL11: the in-use flag is control bit 4 and is also set when an operation is started.
// RL12: the sequencer starts operations, results load on completion, a same-cycle software write wins.
`timescale 1ns/1ps
module mdr_top
  import mdr_pkg::*;
(
  core_clk,
  reset,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  op_start,
  op_kind,
  op_divisor,
  op_busy,
  op_done,
  regs_in_use_flag
);
  input  wire logic                   core_clk;
  input  wire logic                   reset;
  input  wire logic [mdr_pkg::ADDR_W-1:0] reg_addr;
  input  wire logic [15:0]            reg_wdata;
  input  wire logic                   reg_wr;
  input  wire logic                   reg_rd;
  output logic      [15:0]            reg_rdata;
  input  wire logic                   op_start;
  input  wire mdr_pkg::mdr_op_t       op_kind;
  input  wire logic [15:0]            op_divisor;
  output logic                        op_busy;
  output logic                        op_done;
  output logic                        regs_in_use_flag;

  logic [15:0]  muldiv_high_word_reg;
  logic [15:0]  muldiv_low_word_reg;
  logic [15:0]  ctrl_reg;
  mdr_state_t   state_reg;
  mdr_op_t      kind_reg;
  logic         mul_start;
  logic         div_start;
  logic         mul_done;
  logic         div_done;
  logic         div_busy;
  logic [31:0]  product;
  logic [15:0]  quotient;
  logic [15:0]  remainder;
  logic         wr_high;
  logic         wr_low;
  logic         wr_ctrl;
  logic         rd_low;
  logic         res_load;
  logic [7:0]   busy_cnt_reg;

  // one strobe against one register index
  function automatic logic addr_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
    return strobe && (addr == target);
  endfunction

  // whole-word decode only, no bit access [RL10]
  assign wr_high  = addr_hit(reg_wr, reg_addr, ADDR_HIGH);
  assign wr_low   = addr_hit(reg_wr, reg_addr, ADDR_LOW);
  assign wr_ctrl  = addr_hit(reg_wr, reg_addr, ADDR_CTRL);
  assign rd_low   = addr_hit(reg_rd, reg_addr, ADDR_LOW);
  assign mul_start = op_start && (state_reg == MDR_ST_IDLE) && (op_kind == MDR_OP_MUL);
  assign div_start = op_start && (state_reg == MDR_ST_IDLE) && (op_kind != MDR_OP_MUL);
  assign res_load  = mul_done || div_done;

  mdr_mult #(.W(WORD_W)) u_mult (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (mul_start),
    .a        (muldiv_high_word_reg),
    .b        (muldiv_low_word_reg),
    .done     (mul_done),
    .product  (product)
  );

  // dividend taken from high:low as loaded by software [RL3]
  mdr_div #(.W(WORD_W)) u_div (
    .core_clk  (core_clk),
    .reset     (reset),
    .start     (div_start),
    .dividend  ({muldiv_high_word_reg, muldiv_low_word_reg}),
    .divisor   (op_divisor),
    .busy      (div_busy),
    .done      (div_done),
    .quotient  (quotient),
    .remainder (remainder)
  );

  // sequencer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= MDR_ST_IDLE;
      kind_reg  <= MDR_OP_MUL;
    end else begin
      case (state_reg)
        MDR_ST_IDLE: begin
          if (op_start) begin
            state_reg <= MDR_ST_BUSY;
            kind_reg  <= op_kind;
          end
        end
        MDR_ST_BUSY: begin
          if (res_load) begin
            state_reg <= MDR_ST_DONE;
          end
        end
        MDR_ST_DONE: state_reg <= MDR_ST_IDLE;
        default:     state_reg <= MDR_ST_IDLE;
      endcase
    end
  end

  // high word: software write wins over result load [RL12]
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      muldiv_high_word_reg <= WORD_RESET; // [RL8]
    end else if (wr_high) begin
      muldiv_high_word_reg <= reg_wdata; // [RL12]
    end else if (mul_done) begin
      muldiv_high_word_reg <= product[31:16]; // [RL1]
    end else if (div_done) begin
      muldiv_high_word_reg <= remainder; // [RL4]
    end
  end

  // low word
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      muldiv_low_word_reg <= WORD_RESET; // [RL8]
    end else if (wr_low) begin
      muldiv_low_word_reg <= reg_wdata; // [RL12]
    end else if (mul_done) begin
      muldiv_low_word_reg <= product[15:0]; // [RL2]
    end else if (div_done) begin
      muldiv_low_word_reg <= quotient; // [RL5]
    end
  end

  // control register, in-use flag: set wins over clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata & CTRL_MASK; // saved state restore [RL9]
      end
      if (wr_high || wr_low || op_start) begin
        ctrl_reg[IN_USE_BIT] <= 1'b1; // [RL6] [RL11]
      end else if (rd_low) begin
        ctrl_reg[IN_USE_BIT] <= 1'b0; // [RL7]
      end else if (wr_ctrl) begin
        ctrl_reg[IN_USE_BIT] <= reg_wdata[IN_USE_BIT];
      end
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_HIGH: reg_rdata <= muldiv_high_word_reg;
        ADDR_LOW:  reg_rdata <= muldiv_low_word_reg;
        ADDR_CTRL: reg_rdata <= ctrl_reg;
        default:   reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // status outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      op_busy          <= 1'b0;
      op_done          <= 1'b0;
      regs_in_use_flag <= 1'b0;
    end else begin
      op_busy          <= (state_reg != MDR_ST_IDLE) || op_start;
      op_done          <= res_load;
      regs_in_use_flag <= ctrl_reg[IN_USE_BIT];
    end
  end

  // helper: cycles spent away from idle, saturating
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_cnt_reg <= 8'h00;
    end else if (state_reg == MDR_ST_IDLE) begin
      busy_cnt_reg <= 8'h00;
    end else if (busy_cnt_reg != 8'hff) begin
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
    end
  end

  // assertions
  a_mul_high_result: assert property (@(posedge core_clk) disable iff (reset) // [RL1]
    mul_done && !wr_high |=> muldiv_high_word_reg == $past(product[31:16]))
    else $error("high word not product upper half");
  a_mul_low_result: assert property (@(posedge core_clk) disable iff (reset) // [RL2]
    mul_done && !wr_low |=> muldiv_low_word_reg == $past(product[15:0]))
    else $error("low word not product lower half");
  a_div_remainder_load: assert property (@(posedge core_clk) disable iff (reset) // [RL4]
    div_done && !wr_high |=> muldiv_high_word_reg == $past(remainder))
    else $error("high word not remainder");
  a_div_quotient_load: assert property (@(posedge core_clk) disable iff (reset) // [RL5]
    div_done && !wr_low |=> muldiv_low_word_reg == $past(quotient))
    else $error("low word not quotient");
  a_write_sets_flag: assert property (@(posedge core_clk) disable iff (reset) // [RL6]
    (wr_high || wr_low) |=> ctrl_reg[IN_USE_BIT] ##1 regs_in_use_flag)
    else $error("write did not set in-use flag");
  a_low_read_clears: assert property (@(posedge core_clk) disable iff (reset) // [RL7]
    rd_low && !reg_wr && !op_start |=> !ctrl_reg[IN_USE_BIT])
    else $error("low read did not clear flag");
  a_high_read_keeps: assert property (@(posedge core_clk) disable iff (reset) // [RL7]
    reg_rd && reg_addr == ADDR_HIGH && !op_start |=> $stable(ctrl_reg[IN_USE_BIT]))
    else $error("high read changed flag");
  a_reset_zero_words: assert property (@(posedge core_clk) // [RL8]
    $fell(reset) |-> muldiv_high_word_reg == WORD_RESET && muldiv_low_word_reg == WORD_RESET)
    else $error("words not zero after reset");
  a_start_sets_flag: assert property (@(posedge core_clk) disable iff (reset) // [RL11]
    op_start |=> ctrl_reg[IN_USE_BIT])
    else $error("start did not set flag");
  a_write_beats_load: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    wr_low && res_load |=> muldiv_low_word_reg == $past(reg_wdata))
    else $error("software write lost to result");
  a_div_finishes: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    div_start |-> ##33 div_done)
    else $error("divide length wrong");
  a_high_write_lands: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    wr_high |=> muldiv_high_word_reg == $past(reg_wdata))
    else $error("high word write lost");
  a_low_write_lands: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    wr_low |=> muldiv_low_word_reg == $past(reg_wdata))
    else $error("low word write lost");
  a_high_read_data: assert property (@(posedge core_clk) disable iff (reset) // [RL10]
    reg_rd && reg_addr == ADDR_HIGH |=> reg_rdata == $past(muldiv_high_word_reg))
    else $error("high word read data wrong");
  a_low_read_data: assert property (@(posedge core_clk) disable iff (reset) // [RL10]
    reg_rd && reg_addr == ADDR_LOW |=> reg_rdata == $past(muldiv_low_word_reg))
    else $error("low word read data wrong");
  a_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (reset)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero without read");
  a_unmapped_write_ignored: assert property (@(posedge core_clk) disable iff (reset) // [RL10]
    reg_wr && reg_addr > ADDR_CTRL && !res_load |=> $stable(muldiv_high_word_reg) && $stable(muldiv_low_word_reg))
    else $error("unmapped write changed a word");
  a_flag_copy: assert property (@(posedge core_clk) disable iff (reset) // [RL11]
    1'b1 |=> regs_in_use_flag == $past(ctrl_reg[IN_USE_BIT]))
    else $error("flag output not control bit copy");
  a_ctrl_upper_zero: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl_reg & ~CTRL_MASK) == 16'h0000)
    else $error("control upper bits set");
  a_mul_one_cycle: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    mul_start |=> mul_done)
    else $error("multiply length wrong");
  a_div_busy_state: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    div_busy |-> state_reg == MDR_ST_BUSY)
    else $error("divider busy outside busy state");
  a_result_kind: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    res_load |-> mul_done == (kind_reg == MDR_OP_MUL))
    else $error("result from wrong unit");
  a_done_follows_load: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    res_load |=> op_done)
    else $error("done not after result load");
  a_done_pulse: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    op_done |=> !op_done)
    else $error("done longer than one cycle");
  a_busy_while_active: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    state_reg != MDR_ST_IDLE |=> op_busy)
    else $error("busy low during operation");
  a_busy_bounded: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
    busy_cnt_reg <= 8'(2 * DIV_STEPS + 2))
    else $error("operation too long");
  a_state_onehot: assert property (@(posedge core_clk) disable iff (reset)
    $onehot(state_reg))
    else $error("state not one-hot");
  a_reset_outputs: assert property (@(posedge core_clk)
    $fell(reset) |-> reg_rdata == 16'h0000 && !op_busy && !op_done && !regs_in_use_flag)
    else $error("outputs not zero after reset");

  c_mul_done: cover property (@(posedge core_clk) disable iff (reset) mul_done);
  c_div_done: cover property (@(posedge core_clk) disable iff (reset) div_done);
  c_low_read_clear: cover property (@(posedge core_clk) disable iff (reset) ctrl_reg[IN_USE_BIT] ##1 rd_low);
  c_write_collide: cover property (@(posedge core_clk) disable iff (reset) (wr_high || wr_low) && res_load);
endmodule // mdr_top

// *** mdr_top_bench.sv ***
// bench: register access, multiply and divide scenarios for the result block
`timescale 1ns/1ps
module mdr_top_bench;
  import mdr_pkg::*;
  logic            core_clk;
  logic            reset;
  logic [3:0]      reg_addr;
  logic [15:0]     reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [15:0]     reg_rdata;
  logic            op_start;
  mdr_op_t         op_kind;
  logic [15:0]     op_divisor;
  logic            op_busy;
  logic            op_done;
  logic            regs_in_use_flag;
  int              bad_count = 0;
  int              n_tests = 0;
  logic [15:0]     d;
  logic            ok;

  mdr_top mdr_top_inst (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start), .op_kind(op_kind),
    .op_divisor(op_divisor), .op_busy(op_busy), .op_done(op_done), .regs_in_use_flag(regs_in_use_flag));
  mdr_seq_model mdr_seq_model_inst (.core_clk(core_clk), .op_done(op_done), .op_start(op_start),
    .op_kind(op_kind), .op_divisor(op_divisor));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0; reg_wdata <= ~v;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic flag_is(input logic f);
    @(posedge core_clk);
    #1 chk({15'h0000, regs_in_use_flag}, {15'h0000, f});
  endtask

  task automatic t_reset;
    rd(ADDR_HIGH, d); chk(d, 16'h0000);
    rd(ADDR_LOW, d);  chk(d, 16'h0000);
    rd(ADDR_CTRL, d); chk(d, 16'h0000);
  endtask

  task automatic t_flag;
    wr(ADDR_HIGH, 16'hffff); flag_is(1'b1);
    rd(ADDR_HIGH, d); chk(d, 16'hffff);
    flag_is(1'b1);
    rd(ADDR_LOW, d); flag_is(1'b0);
    wr(ADDR_LOW, 16'h8001); flag_is(1'b1);
    rd(ADDR_LOW, d); chk(d, 16'h8001);
    flag_is(1'b0);
    wr(ADDR_CTRL, 16'hffef); rd(ADDR_CTRL, d); chk(d, 16'h00ef);
    wr(ADDR_CTRL, 16'h0000);
    wr(4'h7, 16'h1234); rd(4'h7, d); chk(d, 16'h0000);
    rd(ADDR_HIGH, d); chk(d, 16'hffff);
  endtask

  task automatic t_mul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = {16'h0000, a} * {16'h0000, b};
    wr(ADDR_HIGH, a); wr(ADDR_LOW, b); rd(ADDR_LOW, d);
    flag_is(1'b0);
    mdr_seq_model_inst.start(MDR_OP_MUL, 16'h0000);
    mdr_seq_model_inst.wait_done(ok); chk({15'h0000, ok}, 16'h0001);
    chk({15'h0000, op_busy}, 16'h0001);
    flag_is(1'b1);
    rd(ADDR_HIGH, d); chk(d, p[31:16]);
    chk({15'h0000, op_busy}, 16'h0000);
    rd(ADDR_LOW, d);  chk(d, p[15:0]);
  endtask

  task automatic t_collide(input logic [15:0] a, input logic [15:0] b, input logic [15:0] v);
    logic [31:0] p;
    p = {16'h0000, a} * {16'h0000, b};
    wr(ADDR_HIGH, a); wr(ADDR_LOW, b);
    fork
      mdr_seq_model_inst.start(MDR_OP_MUL, 16'h0000);
      begin @(posedge core_clk); wr(ADDR_LOW, v); end
    join
    rd(ADDR_LOW, d);  chk(d, v);
    rd(ADDR_HIGH, d); chk(d, p[31:16]);
  endtask

  task automatic t_div(input mdr_op_t k, input logic [31:0] n, input logic [15:0] dv, input logic late);
    logic [31:0] q;
    logic [31:0] r;
    q = n / {16'h0000, dv};
    r = n % {16'h0000, dv};
    wr(ADDR_HIGH, n[31:16]); wr(ADDR_LOW, n[15:0]);
    mdr_seq_model_inst.start(k, dv);
    if (late) mdr_seq_model_inst.start(MDR_OP_MUL, 16'h0001);
    mdr_seq_model_inst.wait_done(ok); chk({15'h0000, ok}, 16'h0001);
    rd(ADDR_HIGH, d); chk(d, r[15:0]);
    rd(ADDR_LOW, d);  chk(d, q[15:0]);
  endtask

  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1; reg_addr = 4'h0; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_reset;
    t_flag;
    t_mul(16'h1234, 16'h5678);
    t_mul(16'hffff, 16'hffff);
    t_collide(16'h1234, 16'h0100, 16'h5a5a);
    for (int k = 1; k < 4; k++) t_div(mdr_op_t'(k), 32'h00fe_dcba, 16'h1234, 1'b0);
    t_div(MDR_OP_DIVU, 32'h1233_ffff, 16'h1234, 1'b1);
    end_sim;
  end

  initial begin
    #(5000 * 5);
    bad_count++;
    end_sim;
  end
endmodule // mdr_top_bench
